/* inc/sfr_link_if.sv */
/*
 * carrier between the receiver core, its line sampler and its crc checker.
 * assumes all three sit on the same system clock.
 */
interface sfr_link_if;
    logic bit_valid;
    logic bit_data;
    logic carrier;
    logic crc_clear;
    logic crc_step;
    logic crc_bit;
    logic [15:0] crc_rem;
    modport sampler (output bit_valid, output bit_data, output carrier);
    modport checker_side (input crc_clear, input crc_step, input crc_bit, output crc_rem);
    modport core (input bit_valid, input bit_data, input carrier,
                  output crc_clear, output crc_step, output crc_bit, input crc_rem);
endinterface

/* inc/sfr_pkg.sv */
/*
 * constants of the sdlc frame receiver: register map, field positions,
 * reset values, commands, receive states and check values.
 * assumes nothing beyond a systemverilog compiler.
 */
package sfr_pkg;
    localparam logic [2:0] ADR_CMD = 3'h0, ADR_INT_CFG = 3'h1, ADR_VECTOR = 3'h2;
    localparam logic [2:0] ADR_RCV_CFG = 3'h3, ADR_MODE_CFG = 3'h4, ADR_DATA = 3'h5;
    localparam logic [2:0] ADR_SEC_ADDR = 3'h6, ADR_FLAG = 3'h7;
    // command field of the command register
    localparam int CMD_LSB = 3;
    localparam logic [2:0] CMD_RESET_EXT = 3'h2, CMD_CHAN_RESET = 3'h3;
    localparam logic [2:0] CMD_ARM_FIRST = 3'h4, CMD_ERROR_RESET = 3'h6;
    // interrupt_config_reg
    localparam int IC_EXT_EN = 0, IC_STAT_VEC = 2, IC_MODE_LSB = 3, IC_WAIT_EN = 7;
    localparam logic [1:0] RXI_NONE = 2'h0, RXI_FIRST = 2'h1;
    // receiver_config_reg
    localparam int RC_RX_EN = 0, RC_ADDR_SRCH = 2, RC_HUNT = 4;
    // mode_config_reg
    localparam int MC_MODE_LSB = 4;
    localparam logic [1:0] MODE_SDLC = 2'h2;
    // primary_status_reg / special_status_reg
    localparam int PS_RX_AVAIL = 0, PS_CARRIER = 3, PS_HUNT = 4, PS_ABORT = 7;
    localparam int SS_RES_LSB = 1, SS_OVERRUN = 5, SS_CRC_ERR = 6, SS_EOF = 7;
    // vector codes
    localparam logic [2:0] VEC_NONE = 3'h0, VEC_EXT = 3'h1, VEC_RX = 3'h2, VEC_SPECIAL = 3'h3;
    localparam logic [7:0] RST_REG = 8'h00, RST_FLAG = 8'h7E, GLOBAL_ADDR = 8'hFF;
    localparam logic [15:0] CRC_PRESET = 16'hFFFF, CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_GOOD = 16'h1D0F;
    localparam logic [2:0] ONES_STUFF = 3'h5, ONES_ABORT = 3'h6, DLY_FULL = 3'h7;
    typedef enum logic [1:0] {
        SFR_HUNT = 2'b00,
        SFR_SYNC = 2'b01,
        SFR_DATA = 2'b10,
        SFR_SKIP = 2'b11
    } sfr_state_e;
endpackage

/* rtl/sfr_crc_check.sv */
/*
 * serial receive crc checker, one bit per step, cleared on each flag.
 * assumes bits arrive in line order, least significant first.
 */
module sfr_crc_check (
    input wire logic clk_in,
    input wire logic reset_n_in,
    sfr_link_if.checker_side lk
);
    typedef struct packed {
        logic [15:0] rem;
    } sfr_crc_s;
    sfr_crc_s q, next_q;

    always_comb begin
        next_q = q;
        if (lk.crc_clear) begin
            next_q.rem = sfr_pkg::CRC_PRESET;
        end else if (lk.crc_step) begin
            next_q.rem = {q.rem[14:0], 1'b0} ^
                ((q.rem[15] ^ lk.crc_bit) ? sfr_pkg::CRC_POLY : 16'h0000);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            q.rem <= sfr_pkg::CRC_PRESET;
        end else begin
            q <= next_q;
        end
    end

    assign lk.crc_rem = q.rem;
endmodule

/* rtl/sfr_line_sampler.sv */
/*
 * line sampler: brings link clock, link data and carrier detect into the
 * system clock domain and emits one bit per rising link clock edge.
 * assumes the link clock is much slower than clk_in (8x or more).
 */
module sfr_line_sampler (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic link_clk_in,
    input wire logic link_data_in,
    input wire logic carrier_detect_in,
    sfr_link_if.sampler lk
);
    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] sync;
        logic clk_prev;
        logic bit_valid;
        logic bit_data;
    } sfr_samp_s;
    sfr_samp_s q, next_q;

    always_comb begin
        next_q = q;
        next_q.meta = {carrier_detect_in, link_data_in, link_clk_in};
        // only the second stage is looked at
        next_q.sync = q.meta;
        next_q.clk_prev = q.sync[0];
        next_q.bit_valid = q.sync[0] && !q.clk_prev;
        next_q.bit_data = q.sync[1];
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign lk.bit_valid = q.bit_valid;
    assign lk.bit_data = q.bit_data;
    assign lk.carrier = q.sync[2];
endmodule

/* rtl/sfr_receiver.sv */
/*
 * sdlc frame receiver core: flag hunt, zero deletion, address filter,
 * character hand-off by interrupt or wait/ready, end of frame, abort.
 * assumes a one-cycle register port master and an external dma engine
 * that reads the data register while wait_ready_n_out is low.
 */
// The address map and the plain strobed port were left to the implementer.
module sfr_receiver #(
    parameter bit CHANNEL_B = 1'b1
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic link_clk_in,
    input wire logic link_data_in,
    input wire logic carrier_detect_in,
    output logic wait_ready_n_out,
    output logic rx_int_out,
    output logic ext_int_out,
    output logic special_int_out
);
    typedef struct packed {
        logic [7:0] int_cfg;
        logic [7:0] rcv_cfg;
        logic [7:0] mode_cfg;
        logic [7:0] sec_addr;
        logic [7:0] flag_pat;
        sfr_pkg::sfr_state_e st;
        logic [7:0] raw;
        logic [2:0] ones;
        logic [6:0] dly;
        logic [2:0] dcnt;
        logic [7:0] asm_ch;
        logic [2:0] acnt;
        logic [7:0] rx_buf;
        logic rx_avail;
        logic first_arm;
        logic rx_int;
        logic ext_pend;
        logic overrun;
        logic eof;
        logic crc_err;
        logic [2:0] residue;
        logic abort;
        logic carrier_prev;
        logic [7:0] rdata;
    } sfr_rx_s;

    localparam sfr_rx_s RESET_Q = '{int_cfg: sfr_pkg::RST_REG, rcv_cfg: sfr_pkg::RST_REG,
        mode_cfg: sfr_pkg::RST_REG, sec_addr: sfr_pkg::RST_REG,
        flag_pat: sfr_pkg::RST_FLAG, st: sfr_pkg::SFR_HUNT, default: '0};

    sfr_rx_s q, next_q;
    sfr_link_if lk ();
    logic c_clear, c_step, c_bit;
    logic flag_hit, stuffed, char_done, data_rd, hunt_cmd, active, spc_en;
    logic [7:0] ch;

    sfr_line_sampler u_sampler (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .link_clk_in(link_clk_in),
        .link_data_in(link_data_in),
        .carrier_detect_in(carrier_detect_in),
        .lk(lk.sampler)
    );

    sfr_crc_check u_crc (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .lk(lk.checker_side)
    );

    function automatic logic [2:0] vec_code(input sfr_rx_s s, input logic spc);
        if (spc) begin
            return sfr_pkg::VEC_SPECIAL;
        end else if (s.rx_int) begin
            return sfr_pkg::VEC_RX;
        end else if (s.ext_pend) begin
            return sfr_pkg::VEC_EXT;
        end
        return sfr_pkg::VEC_NONE;
    endfunction

    assign data_rd = rd_in && (addr_in == sfr_pkg::ADR_DATA);
    assign spc_en = q.int_cfg[sfr_pkg::IC_MODE_LSB +: 2] != sfr_pkg::RXI_NONE;
    assign active = q.rcv_cfg[sfr_pkg::RC_RX_EN] &&
                    (q.mode_cfg[sfr_pkg::MC_MODE_LSB +: 2] == sfr_pkg::MODE_SDLC);

    always_comb begin
        logic [2:0] cmd;
        logic ob;
        cmd = wdata_in[sfr_pkg::CMD_LSB +: 3];
        ob = q.dly[0];
        next_q = q;
        c_clear = 1'b0;
        c_step = 1'b0;
        c_bit = ob;
        flag_hit = 1'b0;
        stuffed = 1'b0;
        char_done = 1'b0;
        hunt_cmd = 1'b0;
        ch = {ob, q.asm_ch[7:1]};
        next_q.rdata = 8'h00;
        // host side first so that hardware events below win over clears
        if (rd_in) begin
            unique case (addr_in)
                sfr_pkg::ADR_CMD: next_q.rdata = {q.abort, 2'b00, q.st == sfr_pkg::SFR_HUNT,
                    q.carrier_prev, 2'b00, q.rx_avail};
                sfr_pkg::ADR_INT_CFG: next_q.rdata = {q.eof, q.crc_err, q.overrun, 1'b0,
                    q.residue, 1'b0};
                sfr_pkg::ADR_VECTOR: next_q.rdata = (CHANNEL_B && q.int_cfg[sfr_pkg::IC_STAT_VEC])
                    ? {5'h00, vec_code(q, special_int_out)} : 8'h00;
                sfr_pkg::ADR_DATA: begin
                    next_q.rdata = q.rx_buf;
                    next_q.rx_avail = 1'b0;
                    next_q.rx_int = 1'b0;
                end
                default: next_q.rdata = 8'h00;
            endcase
        end
        if (wr_in) begin
            unique case (addr_in)
                sfr_pkg::ADR_CMD: begin
                    if (cmd == sfr_pkg::CMD_RESET_EXT) begin
                        next_q.ext_pend = 1'b0;
                    end
                    if (cmd == sfr_pkg::CMD_ARM_FIRST) begin
                        next_q.first_arm = 1'b1;
                    end
                    if (cmd == sfr_pkg::CMD_ERROR_RESET) begin
                        next_q.overrun = 1'b0;
                        next_q.eof = 1'b0;
                    end
                    if (cmd == sfr_pkg::CMD_CHAN_RESET) begin
                        next_q = RESET_Q;
                    end
                end
                sfr_pkg::ADR_INT_CFG: next_q.int_cfg = wdata_in;
                sfr_pkg::ADR_RCV_CFG: begin
                    next_q.rcv_cfg = wdata_in;
                    hunt_cmd = wdata_in[sfr_pkg::RC_HUNT];
                end
                sfr_pkg::ADR_MODE_CFG: next_q.mode_cfg = wdata_in;
                sfr_pkg::ADR_SEC_ADDR: next_q.sec_addr = wdata_in;
                sfr_pkg::ADR_FLAG: next_q.flag_pat = wdata_in;
                default: next_q.rdata = next_q.rdata;
            endcase
        end
        // carrier change is an external/status event
        next_q.carrier_prev = lk.carrier;
        if ((lk.carrier != q.carrier_prev) && q.int_cfg[sfr_pkg::IC_EXT_EN]) begin
            next_q.ext_pend = 1'b1;
        end
        if (!active || hunt_cmd) begin
            next_q.st = sfr_pkg::SFR_HUNT;
        end else if (lk.bit_valid) begin
            next_q.raw = {lk.bit_data, q.raw[7:1]};
            next_q.ones = (lk.bit_data && q.ones != 3'h7) ? q.ones + 3'h1 :
                          (lk.bit_data ? q.ones : 3'h0);
            // seven ones in a row is an abort, whatever the state
            if (lk.bit_data && q.ones >= sfr_pkg::ONES_ABORT && !q.abort) begin
                next_q.abort = 1'b1;
                next_q.ext_pend = next_q.ext_pend | q.int_cfg[sfr_pkg::IC_EXT_EN];
                if (q.st != sfr_pkg::SFR_HUNT) begin
                    next_q.st = sfr_pkg::SFR_SKIP;
                end
            end
            if (!lk.bit_data && q.abort) begin
                next_q.abort = 1'b0;
                next_q.ext_pend = next_q.ext_pend | q.int_cfg[sfr_pkg::IC_EXT_EN];
            end
            stuffed = !lk.bit_data && (q.ones == sfr_pkg::ONES_STUFF);
            flag_hit = {lk.bit_data, q.raw[7:1]} == q.flag_pat;
            if (flag_hit) begin
                // flag bits still sit in the delay line and are dropped
                if (q.st == sfr_pkg::SFR_DATA) begin
                    next_q.eof = 1'b1;
                    next_q.crc_err = lk.crc_rem != sfr_pkg::CRC_GOOD;
                    next_q.residue = q.acnt;
                    if (spc_en) begin
                        next_q.int_cfg[sfr_pkg::IC_WAIT_EN] = 1'b0;
                    end
                end
                next_q.st = sfr_pkg::SFR_SYNC;
                c_clear = 1'b1;
                next_q.dcnt = 3'h0;
                next_q.acnt = 3'h0;
            end else if (!stuffed && (q.st == sfr_pkg::SFR_SYNC || q.st == sfr_pkg::SFR_DATA)
                         && !next_q.abort) begin
                // seven-bit delay keeps flag bits away from the assembler
                next_q.dly = {lk.bit_data, q.dly[6:1]};
                if (q.dcnt != sfr_pkg::DLY_FULL) begin
                    next_q.dcnt = q.dcnt + 3'h1;
                end else begin
                    c_step = 1'b1;
                    next_q.asm_ch = ch;
                    next_q.acnt = q.acnt + 3'h1;
                    char_done = q.acnt == 3'h7;
                end
            end
        end
        if (char_done) begin
            if (q.st == sfr_pkg::SFR_SYNC && q.rcv_cfg[sfr_pkg::RC_ADDR_SRCH] &&
                ch != q.sec_addr && ch != sfr_pkg::GLOBAL_ADDR) begin
                next_q.st = sfr_pkg::SFR_SKIP;
            end else begin
                next_q.st = sfr_pkg::SFR_DATA;
                if (q.rx_avail && !data_rd) begin
                    next_q.overrun = 1'b1;
                end
                next_q.rx_buf = ch;
                next_q.rx_avail = 1'b1;
                if (q.int_cfg[sfr_pkg::IC_MODE_LSB +: 2] == sfr_pkg::RXI_FIRST) begin
                    // only the address character of a frame interrupts
                    if (q.first_arm && q.st == sfr_pkg::SFR_SYNC) begin
                        next_q.rx_int = 1'b1;
                        next_q.first_arm = 1'b0;
                    end
                end else if (spc_en) begin
                    next_q.rx_int = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            q <= RESET_Q;
        end else begin
            q <= next_q;
        end
    end

    assign lk.crc_clear = c_clear;
    assign lk.crc_step = c_step;
    assign lk.crc_bit = c_bit;
    assign rdata_out = q.rdata;
    // no wait state while the dma engine is not enabled
    assign wait_ready_n_out = !(q.int_cfg[sfr_pkg::IC_WAIT_EN] && q.rx_avail);
    assign rx_int_out = q.rx_int;
    assign ext_int_out = q.ext_pend;
    assign special_int_out = spc_en && (q.overrun || q.eof);

    sequence s_addr_miss;
        char_done && q.st == sfr_pkg::SFR_SYNC && q.rcv_cfg[sfr_pkg::RC_ADDR_SRCH] &&
        ch != q.sec_addr && ch != sfr_pkg::GLOBAL_ADDR && !hunt_cmd && active;
    endsequence
    sequence s_eof_seen;
        flag_hit && q.st == sfr_pkg::SFR_DATA && spc_en && !hunt_cmd && active && !wr_in;
    endsequence

    property p_sync_by_flag;
        @(posedge clk_in) disable iff (!reset_n_in)
        (q.st != sfr_pkg::SFR_SYNC) ##1 (q.st == sfr_pkg::SFR_SYNC) |-> $past(flag_hit);
    endproperty
    a_sync_by_flag: assert property (p_sync_by_flag) else $error("sync without flag");
    property p_addr_filter;
        @(posedge clk_in) disable iff (!reset_n_in)
        s_addr_miss |=> q.st == sfr_pkg::SFR_SKIP && !$rose(q.rx_avail);
    endproperty
    a_addr_filter: assert property (p_addr_filter) else $error("address miss taken");
    property p_first_only;
        @(posedge clk_in) disable iff (!reset_n_in)
        $rose(q.rx_int) && q.int_cfg[sfr_pkg::IC_MODE_LSB +: 2] == sfr_pkg::RXI_FIRST
        |-> $past(q.st) == sfr_pkg::SFR_SYNC && q.st == sfr_pkg::SFR_DATA && !q.first_arm;
    endproperty
    a_first_only: assert property (p_first_only) else $error("late char interrupt");
    property p_ready_drop;
        @(posedge clk_in) disable iff (!reset_n_in)
        data_rd && !char_done && !wr_in |=> wait_ready_n_out;
    endproperty
    a_ready_drop: assert property (p_ready_drop) else $error("ready held after read");
    property p_overrun;
        @(posedge clk_in) disable iff (!reset_n_in)
        char_done && q.rx_avail && !data_rd && q.st == sfr_pkg::SFR_DATA && spc_en
        && !wr_in |=> q.overrun ##0 special_int_out;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun missed");
    property p_eof;
        @(posedge clk_in) disable iff (!reset_n_in)
        s_eof_seen |=> q.eof && special_int_out && wait_ready_n_out [*2];
    endproperty
    a_eof: assert property (p_eof) else $error("end of frame not handled");
    property p_err_reset;
        @(posedge clk_in) disable iff (!reset_n_in)
        wr_in && addr_in == sfr_pkg::ADR_CMD &&
        wdata_in[sfr_pkg::CMD_LSB +: 3] == sfr_pkg::CMD_ERROR_RESET && !char_done && !flag_hit
        |=> !q.overrun && !q.eof;
    endproperty
    a_err_reset: assert property (p_err_reset) else $error("error reset ignored");
    property p_abort;
        @(posedge clk_in) disable iff (!reset_n_in)
        lk.bit_valid && lk.bit_data && q.ones == sfr_pkg::ONES_ABORT && active && !hunt_cmd
        && !wr_in |=> q.abort && q.st != sfr_pkg::SFR_DATA;
    endproperty
    a_abort: assert property (p_abort) else $error("abort not flagged");
    property p_abort_end;
        @(posedge clk_in) disable iff (!reset_n_in)
        q.abort && lk.bit_valid && !lk.bit_data && active && !hunt_cmd && !wr_in &&
        q.int_cfg[sfr_pkg::IC_EXT_EN] |=> !q.abort && q.ext_pend;
    endproperty
    a_abort_end: assert property (p_abort_end) else $error("abort end lost");
    property p_hunt_only_cmd;
        @(posedge clk_in) disable iff (!reset_n_in)
        (q.st != sfr_pkg::SFR_HUNT) ##1 (q.st == sfr_pkg::SFR_HUNT)
        |-> $past(hunt_cmd) || !$past(active) || $past(wr_in);
    endproperty
    a_hunt_only_cmd: assert property (p_hunt_only_cmd) else $error("unasked hunt");
endmodule

/* testbench/sfr_remote_station.sv */
/*
 * remote station model: drives the serial line with flags, zero-inserted
 * bytes, an inverted check sequence and runs of ones for aborts.
 * assumes the bench calls one task at a time; link clock stands still between calls.
 */
module sfr_remote_station (
    output logic link_clk_out,
    output logic link_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] crc;
    int ones;
    initial begin
        link_clk_out = 1'b0;
        link_data_out = 1'b1;
        crc = 16'hFFFF;
        ones = 0;
    end
    // data turns inverted once the clock stops, so nothing stale looks valid
    task automatic raw_bit(input logic b);
        link_data_out = b;
        #200 link_clk_out = 1'b1;
        #200 link_clk_out = 1'b0;
        link_data_out = ~b;
    endtask
    task automatic stuff_bit(input logic b);
        raw_bit(b);
        ones = b ? ones + 1 : 0;
        if (ones == 5) begin
            raw_bit(1'b0);
            ones = 0;
        end
    endtask
    task automatic data_bit(input logic b);
        crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? 16'h1021 : 16'h0000);
        stuff_bit(b);
    endtask
    task automatic flag();
        for (int i = 0; i < 8; i++) raw_bit(sfr_pkg::RST_FLAG[i]);
        crc = 16'hFFFF;
        ones = 0;
    endtask
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) data_bit(b[i]);
    endtask
    task automatic abort_run(input int n);
        for (int i = 0; i < n; i++) raw_bit(1'b1);
    endtask
    // check sequence goes out inverted, high bit first; corrupt flips its last bit
    task automatic send_frame(input logic [23:0] bytes, input int n, input int extra,
                              input logic corrupt);
        logic [15:0] c;
        #7;
        flag();
        for (int i = 0; i < n; i++) send_byte(bytes[8*i +: 8]);
        for (int i = 0; i < extra; i++) data_bit(1'b0);
        c = ~crc ^ {15'h0, corrupt};
        for (int i = 15; i >= 0; i--) stuff_bit(c[i]);
        flag();
    endtask
endmodule

/* testbench/testbench.sv */
/*
 * self-checking bench of the sdlc frame receiver: register port tasks and
 * frame scenarios run against the remote station model.
 * assumes package, link interface and design files are compiled first.
 */
`define CHECK(what, exp, got) begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("MISMATCH %s expected %0h seen %0h", what, exp, got); \
    end \
end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in;
    logic reset_n_in;
    logic [2:0] addr_in;
    logic [7:0] wdata_in;
    logic wr_in;
    logic rd_in;
    logic [7:0] rdata_out;
    logic link_clk;
    logic link_data;
    logic carrier_detect_in;
    logic wait_ready_n_out;
    logic rx_int_out;
    logic ext_int_out;
    logic special_int_out;
    logic [7:0] d;
    int mismatches;
    int n_checks;
    localparam logic [7:0] SEC = 8'h42;
    localparam logic [7:0] ICFG = 8'h0D; // ext enable, status vector, first-char mode
    sfr_receiver i_dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .link_clk_in(link_clk), .link_data_in(link_data),
        .carrier_detect_in(carrier_detect_in), .wait_ready_n_out(wait_ready_n_out),
        .rx_int_out(rx_int_out), .ext_int_out(ext_int_out),
        .special_int_out(special_int_out)
    );
    sfr_remote_station i_remote (.link_clk_out(link_clk), .link_data_out(link_data));
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 v = rdata_out;
    endtask
    task automatic cmd(input logic [2:0] c);
        wr(sfr_pkg::ADR_CMD, {2'h0, c, 3'h0});
    endtask
    // 0 rx int, 1 ready, 2 special int, 3 ext int
    task automatic await(input int sel);
        logic [3:0] v;
        for (int i = 0; i < 6000; i++) begin
            v = {ext_int_out, special_int_out, ~wait_ready_n_out, rx_int_out};
            if (v[sel] === 1'b1) return;
            @(posedge clk_in);
            #1;
        end
        mismatches++;
        $display("MISMATCH timeout event %0d expected 1 seen 0", sel);
        conclude();
    endtask
    // host side of one frame: address by interrupt, the rest by the handshake
    task automatic serve(input logic [7:0] adr, input logic [15:0] exp, input int ndma,
                         input logic [2:0] res);
        logic [7:0] v;
        await(0);
        `CHECK("ready while disabled", 1'b1, wait_ready_n_out)
        rd(sfr_pkg::ADR_DATA, v);
        `CHECK("address char", adr, v)
        wr(sfr_pkg::ADR_INT_CFG, ICFG | 8'h80);
        for (int k = 0; k < ndma; k++) begin
            await(1);
            rd(sfr_pkg::ADR_DATA, v);
            if (k < 2 && ndma == 4) `CHECK("dma byte", exp[8*k +: 8], v)
            `CHECK("no further rx int", 1'b0, rx_int_out)
        end
        await(2);
        `CHECK("ready after eof", 1'b1, wait_ready_n_out)
        rd(sfr_pkg::ADR_INT_CFG, v);
        `CHECK("eof crc residue", {2'b10, res}, {v[7:6], v[3:1]})
        rd(sfr_pkg::ADR_VECTOR, v);
        `CHECK("vector", sfr_pkg::VEC_SPECIAL, v[2:0])
        cmd(sfr_pkg::CMD_ERROR_RESET);
        `CHECK("special cleared", 1'b0, special_int_out)
    endtask
    initial begin
        reset_n_in = 1'b0;
        addr_in = 3'h0;
        wdata_in = 8'h00;
        wr_in = 1'b0;
        rd_in = 1'b0;
        carrier_detect_in = 1'b0;
        mismatches = 0;
        n_checks = 0;
        repeat (16) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rd(sfr_pkg::ADR_CMD, d);
        `CHECK("hunt at reset", 1'b1, d[sfr_pkg::PS_HUNT])
        `CHECK("ints idle", 4'h1, {rx_int_out, ext_int_out, special_int_out, wait_ready_n_out})
        $display("test reset done");
        wr(sfr_pkg::ADR_MODE_CFG, 8'h20);
        wr(sfr_pkg::ADR_SEC_ADDR, SEC);
        wr(sfr_pkg::ADR_INT_CFG, ICFG);
        cmd(sfr_pkg::CMD_ARM_FIRST);
        wr(sfr_pkg::ADR_RCV_CFG, 8'h15);
        fork
            i_remote.send_frame({8'hFF, 8'h7E, SEC}, 3, 0, 1'b0);
            serve(SEC, 16'hFF7E, 4, 3'h0);
        join
        rd(sfr_pkg::ADR_CMD, d);
        `CHECK("no hunt after eof", 1'b0, d[sfr_pkg::PS_HUNT])
        $display("test matched frame done");
        cmd(sfr_pkg::CMD_ARM_FIRST);
        i_remote.send_frame({16'h0, 8'h55}, 1, 0, 1'b0);
        rd(sfr_pkg::ADR_CMD, d);
        `CHECK("foreign frame", 2'b00, {rx_int_out, d[sfr_pkg::PS_RX_AVAIL]})
        fork
            i_remote.send_frame({16'h0, 8'hFF}, 1, 3, 1'b0);
            serve(8'hFF, 16'h0, 2, 3'h3);
        join
        $display("test address filter done");
        i_remote.send_frame({8'h02, 8'h01, SEC}, 3, 0, 1'b1);
        await(2);
        `CHECK("special on overrun", 1'b1, special_int_out)
        rd(sfr_pkg::ADR_INT_CFG, d);
        `CHECK("overrun crc eof", 3'h7, d[7:5])
        rd(sfr_pkg::ADR_DATA, d);
        cmd(sfr_pkg::CMD_ERROR_RESET);
        `CHECK("special after reset", 1'b0, special_int_out)
        $display("test overrun done");
        i_remote.flag();
        i_remote.send_byte(SEC);
        i_remote.abort_run(7);
        await(3);
        rd(sfr_pkg::ADR_CMD, d);
        `CHECK("abort bit set", 1'b1, d[sfr_pkg::PS_ABORT])
        cmd(sfr_pkg::CMD_RESET_EXT);
        `CHECK("ext cleared", 1'b0, ext_int_out)
        i_remote.raw_bit(1'b0);
        await(3);
        rd(sfr_pkg::ADR_CMD, d);
        `CHECK("abort bit clear", 1'b0, d[sfr_pkg::PS_ABORT])
        cmd(sfr_pkg::CMD_RESET_EXT);
        $display("test abort done");
        carrier_detect_in <= 1'b1;
        await(3);
        rd(sfr_pkg::ADR_CMD, d);
        `CHECK("carrier seen", 1'b1, d[sfr_pkg::PS_CARRIER])
        $display("test carrier done");
        cmd(sfr_pkg::CMD_CHAN_RESET);
        rd(sfr_pkg::ADR_CMD, d);
        `CHECK("channel reset", 2'b01, {ext_int_out, d[sfr_pkg::PS_HUNT]})
        wr(sfr_pkg::ADR_MODE_CFG, 8'h20);
        wr(sfr_pkg::ADR_INT_CFG, 8'h10);
        wr(sfr_pkg::ADR_RCV_CFG, 8'h11);
        fork
            i_remote.send_frame(24'hC35A81, 3, 0, 1'b0);
            for (int k = 0; k < 5; k++) begin
                await(0);
                rd(sfr_pkg::ADR_DATA, d);
                if (k < 3) `CHECK("every char byte", 8'(24'hC35A81 >> (8 * k)), d)
            end
        join
        await(2);
        rd(sfr_pkg::ADR_INT_CFG, d);
        `CHECK("good crc eof", 3'h4, d[7:5])
        cmd(sfr_pkg::CMD_ERROR_RESET);
        $display("test every character done");
        conclude();
    end
endmodule
